// ### verilog/apt_tx_port.sv
// Audio port transmitter: frame timing, slot-0 offset and output pin steering
// Notes on behaviour
// - TDM controller, width zero: one-bclk sync
// - TDM controller, width one: two-bclk sync
// - Width setting only in TDM controller mode
// - Offset zero keeps MSB at standard spot
// - Offset N delays slot 0 by N
// - I2S/LJ offset hits left and right slot 0
// - Five-bit offset drives both output pins
// - Offset upper bits reserved, read zero
// - Select bit zero pin A, one pin B
// - Channel one at bit 0, eight at 7
// - Format codes TDM, I2S, LJ; three reserved
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
module apt_tx_port import apt_pkg::*; (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic [255:0] ch_data_in,
	output logic frame_strobe_out,
	input wire logic bclk_in,
	output logic bclk_out,
	output logic bclk_oe_out,
	input wire logic fsync_in,
	output logic fsync_out,
	output logic fsync_oe_out,
	output logic serial_out_a_out,
	output logic serial_out_a_oe_out,
	output logic serial_out_b_out,
	output logic serial_out_b_oe_out
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		apt_fmt_t fmt;
		logic [7:0] cfg0;
		logic [4:0] ofs;
		logic [7:0] sel;
		logic [1:0] ctrl;
		apt_link_t link;
		logic [7:0] pos;
		logic bclk_q;
		logic fs_q;
		logic [255:0] frame;
		logic a_d;
		logic a_oe_n;
		logic b_d;
		logic b_oe_n;
		logic fs_d;
		logic strobe;
		logic [31:0] rdata;
	} apt_state_t;

	localparam apt_state_t ST_RESET = '{
		fmt: apt_fmt_t'(RST_FMT),
		cfg0: RST_TX_CFG0,
		ofs: RST_TX_OFFSET,
		sel: RST_PIN_SEL,
		ctrl: RST_CTRL,
		link: LINK_WAIT,
		pos: FRAME_LAST,
		bclk_q: 1'b0,
		fs_q: 1'b0,
		frame: '0,
		a_d: 1'b0,
		a_oe_n: 1'b1,
		b_d: 1'b0,
		b_oe_n: 1'b1,
		fs_d: 1'b0,
		strobe: 1'b0,
		rdata: 32'h0000_0000
	};

	apt_state_t st_reg;
	apt_state_t st_next;

	logic bclk_sync;
	logic fsync_sync;
	logic div_bclk;
	logic div_rise;
	logic div_fall;
	logic is_master;
	logic is_enabled;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic addr_ok(input logic [11:0] a);
		logic [7:0] idx;
		idx = a[9:2];
		addr_ok = 1'b0;
		if (a[1:0] == 2'h0 && a[11:10] == 2'h0) begin
			addr_ok = (idx == IDX_PORT_CFG) || (idx == IDX_TX_CFG0)
				|| (idx == IDX_TX_OFFSET) || (idx == IDX_PIN_SEL)
				|| (idx == IDX_CTRL) || (idx == IDX_STATUS);
		end
	endfunction

	function automatic logic [31:0] read_word(input apt_state_t s, input logic [11:0] a);
		logic [31:0] w;
		w = 32'h0000_0000;
		if (addr_ok(a)) begin
			unique case (a[9:2])
				IDX_PORT_CFG: begin
					w[FMT_LSB +: 2] = s.fmt;
				end
				IDX_TX_CFG0: begin
					w[7:0] = s.cfg0;
				end
				IDX_TX_OFFSET: begin
					w[4:0] = s.ofs;
				end
				IDX_PIN_SEL: begin
					w[7:0] = s.sel;
				end
				IDX_CTRL: begin
					w[1:0] = s.ctrl;
				end
				IDX_STATUS: begin
					w[0] = (s.link == LINK_RUN);
					w[STAT_POS_LSB +: 8] = s.pos;
				end
				default: begin
					w = 32'h0000_0000;
				end
			endcase
		end
		read_word = w;
	endfunction

	// Maps a frame position to the channel and bit it carries, if any
	function automatic apt_bit_t slot_decode(input logic [7:0] p, input apt_fmt_t f, input logic [4:0] o);
		logic [8:0] rel;
		logic [8:0] start;
		logic [8:0] e;
		apt_bit_t r;
		rel = (f == FMT_TDM) ? {1'b0, p} : {2'b00, p[6:0]};
		start = {8'h00, (f == FMT_I2S)};
		start = start + {4'h0, o};
		e = rel - start;
		r.valid = (rel >= start);
		r.bidx = ~e[4:0];
		if (f == FMT_TDM) begin
			r.ch = e[7:5];
		end else begin
			r.ch = {p[7], e[6:5]};
		end
		slot_decode = r;
	endfunction

	// ----------------------------------------
	// Link pins and clock source
	// ----------------------------------------
	apt_sync2 u_sync_bclk (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.level_in(bclk_in),
		.level_out(bclk_sync)
	);

	apt_sync2 u_sync_fsync (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.level_in(fsync_in),
		.level_out(fsync_sync)
	);

	apt_bclk_div u_div (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.run_in(is_master & is_enabled),
		.bclk_out(div_bclk),
		.rise_out(div_rise),
		.fall_out(div_fall)
	);

	assign is_master = st_reg.ctrl[CTRL_MASTER_BIT];
	assign is_enabled = st_reg.ctrl[CTRL_ENABLE_BIT];

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic wr;
		logic rise;
		logic fall;
		logic start;
		logic [7:0] nxt;
		logic [7:0] ahead;
		logic pin;
		logic fill_z;
		apt_bit_t bi;
		wr = 1'b0;
		rise = 1'b0;
		fall = 1'b0;
		start = 1'b0;
		nxt = 8'h00;
		ahead = 8'h00;
		pin = 1'b0;
		fill_z = 1'b0;
		bi = '0;
		st_next = st_reg;
		st_next.strobe = 1'b0;

		// Register access
		if (psel_in && !penable_in) begin
			st_next.rdata = read_word(st_reg, paddr_in);
		end
		wr = psel_in & penable_in & pwrite_in & addr_ok(paddr_in);
		if (wr) begin
			unique case (paddr_in[9:2])
				IDX_PORT_CFG: begin
					if (pwdata_in[FMT_LSB +: 2] != FMT_RSVD) begin
						st_next.fmt = apt_fmt_t'(pwdata_in[FMT_LSB +: 2]);
					end
				end
				IDX_TX_CFG0: begin
					st_next.cfg0 = pwdata_in[7:0];
				end
				IDX_TX_OFFSET: begin
					st_next.ofs = pwdata_in[4:0];
				end
				IDX_PIN_SEL: begin
					// bit n is channel n plus one
					st_next.sel = pwdata_in[7:0];
				end
				IDX_CTRL: begin
					st_next.ctrl = pwdata_in[1:0];
				end
				default: begin
					st_next.ctrl = st_reg.ctrl;
				end
			endcase
		end

		// Link clock edges
		st_next.bclk_q = bclk_sync;
		if (is_master) begin
			rise = div_rise;
			fall = div_fall;
		end else begin
			rise = bclk_sync & ~st_reg.bclk_q;
			fall = ~bclk_sync & st_reg.bclk_q;
		end

		nxt = st_reg.pos + 8'h01;
		if (rise) begin
			st_next.fs_q = fsync_sync;
			// target frames follow the external sync
			if (st_reg.fmt == FMT_I2S) begin
				start = st_reg.fs_q & ~fsync_sync;
			end else begin
				start = ~st_reg.fs_q & fsync_sync;
			end
			if (!is_master && start) begin
				nxt = 8'h00;
			end
			st_next.pos = nxt;
			// Sample words one bit ahead of frame position 0
			if (nxt == FRAME_LAST) begin
				st_next.frame = ch_data_in;
				st_next.strobe = 1'b1;
			end
		end

		unique case (st_reg.link)
			LINK_WAIT: begin
				if (is_enabled && (is_master || (rise && start))) begin
					st_next.link = LINK_RUN;
				end
			end
			LINK_RUN: begin
				if (!is_enabled) begin
					st_next.link = LINK_WAIT;
				end
			end
		endcase

		// Outputs change on the falling edge for the next position
		ahead = st_reg.pos + 8'h01;
		bi = slot_decode(ahead, st_reg.fmt, st_reg.ofs);
		fill_z = st_reg.cfg0[CFG0_FILL_BIT];
		if (st_reg.link != LINK_RUN || !is_enabled) begin
			st_next.a_d = 1'b0;
			st_next.a_oe_n = 1'b1;
			st_next.b_d = 1'b0;
			st_next.b_oe_n = 1'b1;
			st_next.fs_d = 1'b0;
		end else if (fall) begin
			pin = st_reg.sel[bi.ch];
			st_next.a_d = 1'b0;
			st_next.a_oe_n = fill_z;
			st_next.b_d = 1'b0;
			st_next.b_oe_n = fill_z;
			if (bi.valid) begin
				// steer to pin A or B
				if (pin) begin
					st_next.b_d = st_reg.frame[{bi.ch, bi.bidx}];
					st_next.b_oe_n = 1'b0;
				end else begin
					st_next.a_d = st_reg.frame[{bi.ch, bi.bidx}];
					st_next.a_oe_n = 1'b0;
				end
			end
			unique case (st_reg.fmt)
				FMT_I2S: begin
					st_next.fs_d = ahead[7];
				end
				FMT_LJ: begin
					st_next.fs_d = ~ahead[7];
				end
				default: begin
					st_next.fs_d = (ahead == 8'h00);
					// second bclk extends a started pulse
					if (st_reg.cfg0[CFG0_WIDTH_BIT] && ahead == 8'h01 && st_reg.fs_d) begin
						st_next.fs_d = 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_reg <= ST_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Zero-wait slave; read data was captured in the setup cycle
	assign pready_out = 1'b1;
	assign pslverr_out = psel_in & penable_in & ~addr_ok(paddr_in);
	assign prdata_out = st_reg.rdata;
	assign frame_strobe_out = st_reg.strobe;

	// Link clock and sync are driven only as controller
	assign bclk_out = div_bclk;
	assign bclk_oe_out = ~(is_master & is_enabled);
	assign fsync_out = st_reg.fs_d;
	assign fsync_oe_out = ~(is_master & is_enabled);

	// both pins share the same offset timing
	assign serial_out_a_out = st_reg.a_d;
	assign serial_out_a_oe_out = st_reg.a_oe_n;
	assign serial_out_b_out = st_reg.b_d;
	assign serial_out_b_oe_out = st_reg.b_oe_n;

endmodule // apt_tx_port

// ### verilog/apt_pkg.sv
// Shared constants, types and field layout of the audio port transmit block
package apt_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned BCLK_PERIOD_NS = 160;
	localparam int unsigned BCLK_HALF_CYC = BCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam logic [3:0] BCLK_HALF_LAST = 4'(BCLK_HALF_CYC - 1);

	// ----------------------------------------
	// Register indices (byte address is index times four)
	// ----------------------------------------
	localparam logic [7:0] IDX_PORT_CFG = 8'h1a;
	localparam logic [7:0] IDX_TX_CFG0 = 8'h1b;
	localparam logic [7:0] IDX_TX_OFFSET = 8'h1c;
	localparam logic [7:0] IDX_PIN_SEL = 8'h1d;
	localparam logic [7:0] IDX_CTRL = 8'h40;
	localparam logic [7:0] IDX_STATUS = 8'h41;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int unsigned FMT_LSB = 6;
	localparam int unsigned CFG0_FILL_BIT = 6;
	localparam int unsigned CFG0_WIDTH_BIT = 0;
	localparam int unsigned CTRL_ENABLE_BIT = 0;
	localparam int unsigned CTRL_MASTER_BIT = 1;
	localparam int unsigned STAT_POS_LSB = 8;
	localparam logic [1:0] RST_FMT = 2'h0;
	localparam logic [7:0] RST_TX_CFG0 = 8'h00;
	localparam logic [4:0] RST_TX_OFFSET = 5'h00;
	localparam logic [7:0] RST_PIN_SEL = 8'h00;
	localparam logic [1:0] RST_CTRL = 2'h0;

	// ----------------------------------------
	// Frame layout
	// ----------------------------------------
	localparam logic [7:0] FRAME_LAST = 8'hff;
	localparam logic [8:0] FRAME_SPAN = 9'h100;
	localparam logic [8:0] HALF_SPAN = 9'h080;

	typedef enum logic [1:0] {
		FMT_TDM = 2'h0,
		FMT_I2S = 2'h1,
		FMT_LJ = 2'h2,
		FMT_RSVD = 2'h3
	} apt_fmt_t;

	typedef enum logic {
		LINK_WAIT = 1'b0,
		LINK_RUN = 1'b1
	} apt_link_t;

	typedef struct packed {
		logic valid;
		logic [2:0] ch;
		logic [4:0] bidx;
	} apt_bit_t;

	typedef struct packed {
		logic s1;
		logic s2;
	} apt_sync_t;

	typedef struct packed {
		logic [3:0] cnt;
		logic lvl;
	} apt_div_t;

endpackage

// ### verilog/apt_sync2.sv
// Two-flop synchroniser for one pin level
`timescale 1ns/1ps
module apt_sync2 import apt_pkg::*; (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic level_in,
	output logic level_out
);

	apt_sync_t sync_reg;
	apt_sync_t sync_next;

	// First stage feeds only the second stage
	always_comb begin
		sync_next.s1 = level_in;
		sync_next.s2 = sync_reg.s1;
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sync_reg <= '0;
		end else begin
			sync_reg <= sync_next;
		end
	end

	assign level_out = sync_reg.s2;

endmodule // apt_sync2

// ### verilog/apt_bclk_div.sv
// Bit clock divider used when the port drives the link clock
`timescale 1ns/1ps
module apt_bclk_div import apt_pkg::*; (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic run_in,
	output logic bclk_out,
	output logic rise_out,
	output logic fall_out
);

	apt_div_t div_reg;
	apt_div_t div_next;
	logic wrap;

	always_comb begin
		div_next = div_reg;
		wrap = (div_reg.cnt == BCLK_HALF_LAST);
		if (!run_in) begin
			div_next = '0;
		end else if (wrap) begin
			div_next.cnt = 4'h0;
			div_next.lvl = ~div_reg.lvl;
		end else begin
			div_next.cnt = div_reg.cnt + 4'h1;
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_next;
		end
	end

	// Pulses mark the last cycle before the level flips
	assign bclk_out = div_reg.lvl;
	assign rise_out = run_in & wrap & ~div_reg.lvl;
	assign fall_out = run_in & wrap & div_reg.lvl;

endmodule // apt_bclk_div

// ### tb/apt_tx_port_chk.sv
// Assertions on the transmitter's register bus and frame timing
`timescale 1ns/1ps
module apt_tx_port_chk (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic frame_strobe_out,
	input wire logic bclk_oe_out,
	input wire logic fsync_out,
	input wire logic fsync_oe_out
);
	logic acc, wr, mapped;
	logic [4:0] off_reg;
	logic [7:0] pin_reg;
	logic wid_reg;
	logic [11:0] high_reg;
	assign acc = psel_in && penable_in;
	assign wr = acc && pwrite_in;
	assign mapped = paddr_in inside {12'h068, 12'h06c, 12'h070, 12'h074, 12'h100, 12'h104};

	// Shadows let the read and width checks know the programmed settings
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			off_reg <= 5'h00;
			pin_reg <= 8'h00;
			wid_reg <= 1'b0;
			high_reg <= 12'h000;
		end else begin
			if (wr && paddr_in == 12'h070)
				off_reg <= pwdata_in[4:0];
			if (wr && paddr_in == 12'h074)
				pin_reg <= pwdata_in[7:0];
			if (wr && paddr_in == 12'h06c)
				wid_reg <= pwdata_in[0];
			high_reg <= fsync_out ? high_reg + 12'h001 : 12'h000;
		end
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);

	sequence s_read_offset;
		acc && !pwrite_in && paddr_in == 12'h070;
	endsequence
	sequence s_read_pins;
		acc && !pwrite_in && paddr_in == 12'h074;
	endsequence
	// Half-frame syncs of I2S and LJ are far longer and stay out
	sequence s_pulse_end;
		$fell(fsync_out) && !fsync_oe_out && high_reg < 12'h064;
	endsequence

	chk_ready_high: assert property (pready_out) else $error("ready low");
	chk_err_map: assert property (acc |-> pslverr_out == !mapped) else $error("bad error flag");
	chk_unmapped_zero: assert property (acc && !pwrite_in && !mapped |-> prdata_out == 32'h0000_0000)
		else $error("unmapped read not zero");
	chk_offset_read: assert property (s_read_offset |-> prdata_out == {27'h000_0000, off_reg})
		else $error("offset readback wrong");
	chk_pins_read: assert property (s_read_pins |-> prdata_out == {24'h00_0000, pin_reg})
		else $error("pin select readback wrong");
	chk_oe_pair: assert property (bclk_oe_out == fsync_oe_out) else $error("enables differ");
	chk_sync_width: assert property (s_pulse_end |-> high_reg == (wid_reg ? 12'h020 : 12'h010))
		else $error("sync width wrong");
	chk_strobe_gap: assert property (frame_strobe_out |=> !frame_strobe_out [*8]) else $error("strobe too long");
endmodule // apt_tx_port_chk

bind apt_tx_port apt_tx_port_chk chk (.ref_clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
	.pwdata_in, .prdata_out, .pready_out, .pslverr_out, .frame_strobe_out, .bclk_oe_out, .fsync_out, .fsync_oe_out);

// ### tb/apt_host_model.sv
// Host audio port: makes link clock and frame sync for target mode
`timescale 1ns/1ps
module apt_host_model (
	input wire logic run_in,
	input wire logic [1:0] fmt_in,
	output logic bclk_out,
	output logic fsync_out
);
	int pos = 255;
	initial begin
		bclk_out = 1'b0;
		fsync_out = 1'b0;
		#3;
		// Clock stands still while idle
		forever begin
			#80;
			if (run_in) begin
				bclk_out = ~bclk_out;
				if (!bclk_out) begin
					pos = (pos + 1) % 256;
					fsync_out = (fmt_in == 2'h0) ? (pos == 0) : ((fmt_in == 2'h1) ? (pos >= 128) : (pos < 128));
				end
			end
		end
	end
endmodule // apt_host_model

// ### tb/apt_tx_port_test.sv
// Self-checking bench for the audio port transmitter
`timescale 1ns/1ps
module apt_tx_port_test;
	logic ref_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic psel_in = 1'b0;
	logic penable_in = 1'b0;
	logic pwrite_in = 1'b0;
	logic [11:0] paddr_in = 12'h000;
	logic [31:0] pwdata_in = 32'h0000_0000;
	logic [255:0] ch_data_in = '0;
	logic run = 1'b0;
	logic ctl = 1'b0;
	logic [1:0] hfmt = 2'h0;
	logic [31:0] seed = 32'h0000_02f3;
	logic [31:0] prdata_out;
	logic pready_out, pslverr_out, frame_strobe_out, bclk_in, bclk_out, bclk_oe_out, fsync_in, fsync_out;
	logic fsync_oe_out, serial_out_a_out, serial_out_a_oe_out, serial_out_b_out, serial_out_b_oe_out;
	int num_errors = 0;
	int samples_checked = 0;
	wire sck = ctl ? bclk_out : bclk_in;
	wire fs = ctl ? fsync_out : fsync_in;

	always #5 ref_clk_in = ~ref_clk_in;

	apt_tx_port dut (.ref_clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
		.prdata_out, .pready_out, .pslverr_out, .ch_data_in, .frame_strobe_out, .bclk_in, .bclk_out,
		.bclk_oe_out, .fsync_in, .fsync_out, .fsync_oe_out, .serial_out_a_out, .serial_out_a_oe_out,
		.serial_out_b_out, .serial_out_b_oe_out);
	apt_host_model host (.run_in(run), .fmt_in(hfmt), .bclk_out(bclk_in), .fsync_out(fsync_in));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic err,
		output logic [31:0] r);
		@(posedge ref_clk_in);
		psel_in <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in <= wr;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge ref_clk_in);
		penable_in <= 1'b1;
		do @(posedge ref_clk_in); while (pready_out !== 1'b1);
		r = prdata_out;
		check(32'(pslverr_out), 32'(err));
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask

	// Returns {enable B, enable A, pin B, pin A}; enables are active low, idle cycles carry fill z
	function automatic logic [3:0] expect_bits(int p, int f, int n, logic [7:0] ps, logic z);
		int len, base, q, s;
		logic d;
		len = (f == 0) ? 256 : 128;
		base = p / len * len;
		q = p - base - n - ((f == 1) ? 1 : 0);
		if (q < 0)
			return {z, z, 2'b00};
		s = base / 32 + q / 32;
		d = ch_data_in[32 * s + 31 - q % 32];
		return ps[s] ? {1'b0, z, d, 1'b0} : {z, 1'b0, 1'b0, d};
	endfunction

	task automatic run_case(input int i);
		logic [31:0] r;
		logic [3:0] g;
		logic [7:0] ps;
		logic w;
		logic z;
		int f, n, k;
		f = (i == 5) ? 0 : i % 3;
		w = (i >= 3);
		z = (i == 4);
		n = (i == 0) ? 0 : (i == 1) ? 31 : int'(rnd() % 32);
		ps = 8'(rnd());
		apb(1'b1, 12'h100, 32'h0000_0000, 1'b0, r);
		apb(1'b1, 12'h068, 32'(f) << 6, 1'b0, r);
		apb(1'b1, 12'h06c, 32'(w) | (32'(z) << 6), 1'b0, r);
		apb(1'b1, 12'h070, 32'(n), 1'b0, r);
		apb(1'b1, 12'h074, 32'(ps), 1'b0, r);
		ctl <= (i < 5);
		hfmt <= 2'(f);
		run <= (i == 5);
		apb(1'b1, 12'h100, (i < 5) ? 32'h0000_0003 : 32'h0000_0001, 1'b0, r);
		// First frame after enabling may carry stale words
		repeat (2) begin
			wait (fs === (f == 1));
			wait (fs === (f != 1));
		end
		for (int p = 0; p < 256; p++) begin
			@(posedge sck);
			g = {serial_out_b_oe_out, serial_out_a_oe_out, serial_out_b_out, serial_out_a_out};
			check(32'(g), 32'(expect_bits(p, f, n, ps, z)));
			// As controller the word strobe comes with the bclk rise that reaches the last position
			if (ctl) begin
				@(negedge ref_clk_in);
				check(32'(frame_strobe_out), 32'(p == 255));
			end
		end
		check(32'(fsync_oe_out), 32'(i == 5));
		if (f == 0 && i < 5) begin
			wait (fsync_out === 1'b1);
			k = 0;
			while (fsync_out === 1'b1) begin
				@(negedge ref_clk_in);
				k += int'(fsync_out);
			end
			check(32'(k), 32'(w ? 32 : 16));
		end
		$display("case %0d done", i);
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		logic [31:0] r;
		logic [255:0] d;
		for (int j = 0; j < 8; j++)
			d[32 * j +: 32] = rnd();
		repeat (20) @(posedge ref_clk_in);
		ch_data_in <= d;
		rst_in <= 1'b0;
		apb(1'b0, 12'h070, 32'h0, 1'b0, r);
		check(r, 32'h0000_0000);
		apb(1'b0, 12'h074, 32'h0, 1'b0, r);
		check(r, 32'h0000_0000);
		apb(1'b0, 12'h104, 32'h0, 1'b0, r);
		check(r, 32'h0000_ff00);
		apb(1'b1, 12'h06c, 32'h0000_0041, 1'b0, r);
		apb(1'b0, 12'h06c, 32'h0, 1'b0, r);
		check(r, 32'h0000_0041);
		apb(1'b1, 12'h070, 32'h0000_001f, 1'b0, r);
		apb(1'b0, 12'h070, 32'h0, 1'b0, r);
		check(r, 32'h0000_001f);
		apb(1'b1, 12'h068, 32'h0000_00c0, 1'b0, r);
		apb(1'b0, 12'h068, 32'h0, 1'b0, r);
		check(r, 32'h0000_0000);
		apb(1'b0, 12'h072, 32'h0, 1'b1, r);
		check(r, 32'h0000_0000);
		$display("register case done");
		for (int i = 0; i < 6; i++)
			run_case(i);
		report_and_stop();
	end

	// Six cases of about three frames each fit well inside this span
	initial begin
		#1ms;
		num_errors++;
		report_and_stop();
	end
endmodule // apt_tx_port_test
